// file: rtl/fcs_pkg.sv
// Constants, field layouts and carrier types for the flyback charge sequencer.
// Assumes a 100 MHz control clock and an AHB-Lite register bus.

package fcs_pkg;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_HZ            = 100_000_000;
   localparam int START_DELAY_NS    = 2000;
   localparam int START_DELAY_CYC   = (START_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int SLOW_CLK_HZ       = 26_000;
   localparam int SLOW_DIV_CYC      = CLK_HZ / SLOW_CLK_HZ;
   localparam int TIMEOUT_US        = 500;
   localparam int TIMEOUT_CYC       = TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int BLANK_NS          = 1500;
   localparam int BLANK_CYC         = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int REFRESH_DUTY_DIV  = 20;
   localparam int REFRESH_CYC       = BLANK_CYC * REFRESH_DUTY_DIV;
   localparam int LEVEL_STEP_CYC    = REFRESH_CYC / 10;

   // ***********************************************
   // Peak current levels, in tenths of maximum, and start-up wait requests, in slow ticks
   // ***********************************************
   localparam logic [3:0] LEVEL_MAX  = 4'hA;
   localparam logic [3:0] LEVEL_MIN  = 4'h1;
   localparam logic [3:0] REQ_RESET  = 4'h1;
   localparam logic [3:0] REQ_MAX    = 4'hF;

   // ***********************************************
   // Register map (byte offsets)
   // ***********************************************
   localparam logic [7:0]  CTRL_OFS       = 8'h00;
   localparam logic [7:0]  STATUS_OFS     = 8'h04;
   localparam int          CTRL_EN_BIT    = 0;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
   localparam int          ST_MODE_LSB    = 0;
   localparam int          ST_STATE_LSB   = 2;
   localparam int          ST_MASTER_BIT  = 4;
   localparam int          ST_GATE_BIT    = 5;
   localparam int          ST_DONE_BIT    = 6;
   localparam int          ST_FAULT_BIT   = 7;
   localparam int          ST_BOUND_BIT   = 8;
   localparam int          ST_LEVEL_LSB   = 12;
   localparam int          ST_REQ_LSB     = 16;

   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

   // ***********************************************
   // Types
   // ***********************************************
   typedef struct packed {
      logic start;
      logic fb_below_low;
      logic fb_above_high;
      logic fb_demand;
      logic ilim_trip;
      logic iaux_trip;
      logic vout_target;
      logic node_above_thr;
      logic supply_lockout;
   } fcs_cmp_t;

   typedef enum logic [1:0] {
      MODE_CHARGE   = 2'b00,
      MODE_REGULATE = 2'b01,
      MODE_NOLOAD   = 2'b10
   } fcs_mode_t;

   typedef enum logic [1:0] {
      SEQ_OFF   = 2'b00,
      SEQ_DELAY = 2'b01,
      SEQ_RUN   = 2'b10,
      SEQ_STOP  = 2'b11
   } fcs_seq_t;

endpackage

// file: rtl/fcs_sequencer.sv
// Control sequencer for a flyback capacitor charger and regulator.
// Assumes asynchronous comparator and start inputs, one 100 MHz clock,
// and a single AHB-Lite master for the control and status registers.

`timescale 1ns/1ps

module fcs_sequencer #(
   parameter int TIMEOUT_CYCLES = fcs_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic              MCLK_I,
   input  wire logic              RST_B_I,
   // Comparators and start input (asynchronous)
   input  wire fcs_pkg::fcs_cmp_t CMP_I,
   // Power stage
   output logic                   GATE_O,
   output logic                   DETECT_THR_SEL_O,
   output logic [3:0]             ILIM_LEVEL_O,
   // Open-drain indicators
   output logic                   DONE_O,
   output logic                   DONE_OE_O,
   output logic                   FAULT_O,
   output logic                   FAULT_OE_O,
   // AHB-Lite slave
   input  wire logic              HSEL_I,
   input  wire logic [31:0]       HADDR_I,
   input  wire logic [1:0]        HTRANS_I,
   input  wire logic              HWRITE_I,
   input  wire logic [2:0]        HSIZE_I,
   input  wire logic [31:0]       HWDATA_I,
   input  wire logic              HREADY_I,
   output logic [31:0]            HRDATA_O,
   output logic                   HREADYOUT_O,
   output logic                   HRESP_O
);
   import fcs_pkg::*;

   function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
      hit = (addr[31:8] == 24'h00_0000) && (addr[7:2] == ofs[7:2]);
   endfunction

   function automatic logic [11:0] window_end(input logic [3:0] lvl);
      window_end = 12'(32'(lvl) * LEVEL_STEP_CYC - BLANK_CYC);
   endfunction

   // ***********************************************
   // Input synchronisers
   // ***********************************************
   fcs_cmp_t cmp_meta;
   fcs_cmp_t cmp;
   logic     start_d;
   logic     node_d;

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         cmp_meta <= '0;
         cmp      <= '0;
         start_d  <= 1'b0;
         node_d   <= 1'b0;
      end else begin
         cmp_meta <= CMP_I;
         cmp      <= cmp_meta;
         start_d  <= cmp.start;
         node_d   <= cmp.node_above_thr;
      end
   end

   logic start_rise;
   logic start_fall;
   assign start_rise = cmp.start & ~start_d;
   assign start_fall = ~cmp.start & start_d;

   // ***********************************************
   // Mode from feedback comparators
   // ***********************************************
   fcs_mode_t mode;
   always_comb begin
      if (cmp.fb_below_low) begin
         mode = MODE_CHARGE;
      end else if (cmp.fb_above_high) begin
         mode = MODE_NOLOAD;
      end else begin
         mode = MODE_REGULATE;
      end
   end

   // ***********************************************
   // Registers
   // ***********************************************
   logic [31:0] ctrl;
   logic        wr_pend;
   logic [31:0] wr_addr;
   logic        sw_enable;
   assign sw_enable = ctrl[CTRL_EN_BIT];

   logic addr_valid;
   assign addr_valid = HSEL_I & HREADY_I & (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);

   // ***********************************************
   // Sequencer state
   // ***********************************************
   fcs_seq_t    state;
   logic [7:0]  delay_cnt;
   logic        startup_shot;
   logic        master;
   logic        fault;
   logic        done;

   // Fault latch; a start toggle only clears it once the supply is back
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         fault <= 1'b0;
      end else if (cmp.supply_lockout) begin
         fault <= 1'b1;
      end else if (start_rise) begin
         fault <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state        <= SEQ_OFF;
         delay_cnt    <= '0;
         startup_shot <= 1'b0;
      end else begin
         startup_shot <= 1'b0;
         unique case (state)
            SEQ_OFF, SEQ_STOP: begin
               // Supply must be in range at the toggle itself
               if (start_rise && sw_enable && !cmp.supply_lockout) begin
                  state     <= SEQ_DELAY;
                  delay_cnt <= '0;
               end else if (start_fall) begin
                  state <= SEQ_OFF;
               end
            end
            SEQ_DELAY: begin
               if (!cmp.start || fault || !sw_enable) begin
                  state <= SEQ_OFF;
               end else if (delay_cnt == 8'(START_DELAY_CYC - 1)) begin
                  state        <= SEQ_RUN;
                  startup_shot <= 1'b1;
               end else begin
                  delay_cnt <= delay_cnt + 8'h01;
               end
            end
            SEQ_RUN: begin
               if (!cmp.start || !sw_enable) begin
                  state <= SEQ_OFF;
               end else if (fault) begin
                  state <= SEQ_STOP;
               end else if (mode == MODE_CHARGE && cmp.vout_target && !GATE_O) begin
                  state <= SEQ_STOP;
               end
            end
         endcase
      end
   end

   // Master latch follows the sequencer: set by the one-shot, cleared on stop
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         master <= 1'b0;
      end else if (startup_shot) begin
         master <= 1'b1;
      end else if (state != SEQ_RUN) begin
         master <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         done <= 1'b0;
      end else if (state == SEQ_RUN && mode == MODE_CHARGE && cmp.vout_target && !GATE_O) begin
         done <= 1'b1;
      end else if (startup_shot || state == SEQ_OFF) begin
         done <= 1'b0;
      end
   end

   // ***********************************************
   // Zero-energy detect
   // ***********************************************
   logic armed;
   logic zed_pulse;

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         armed     <= 1'b0;
         zed_pulse <= 1'b0;
      end else begin
         zed_pulse <= 1'b0;
         if (GATE_O) begin
            armed <= 1'b0;
         end else if (cmp.node_above_thr) begin
            armed <= 1'b1;
         end else if (node_d && armed) begin
            armed     <= 1'b0;
            zed_pulse <= 1'b1;
         end
      end
   end

   // ***********************************************
   // Start-up protection
   // ***********************************************
   logic [11:0] slow_div;
   logic        slow_tick;
   logic [3:0]  req_cnt;
   logic [3:0]  cnt2;
   logic [16:0] cnt1;
   logic        boundary;
   logic        prot_out;

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         slow_div  <= '0;
         slow_tick <= 1'b0;
      end else if (slow_div == 12'(SLOW_DIV_CYC - 1)) begin
         slow_div  <= '0;
         slow_tick <= 1'b1;
      end else begin
         slow_div  <= slow_div + 12'h001;
         slow_tick <= 1'b0;
      end
   end

   // Auxiliary trips lengthen the wait so secondary current can decay
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         req_cnt <= REQ_RESET;
      end else if (startup_shot) begin
         req_cnt <= REQ_RESET;
      end else if (cmp.iaux_trip && GATE_O && req_cnt != REQ_MAX) begin
         req_cnt <= req_cnt + 4'h1;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         cnt2 <= '0;
      end else if (GATE_O) begin
         cnt2 <= '0;
      end else if (slow_tick && cnt2 != REQ_MAX) begin
         cnt2 <= cnt2 + 4'h1;
      end
   end

   assign prot_out = !boundary && (cnt2 >= req_cnt);

   // Mode latch and timeout counter
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         boundary <= 1'b0;
         cnt1     <= '0;
      end else if (startup_shot) begin
         boundary <= 1'b0;
         cnt1     <= '0;
      end else if (zed_pulse) begin
         boundary <= 1'b1;
         cnt1     <= 17'(TIMEOUT_CYCLES - 1);
      end else if (boundary) begin
         if (cnt1 == '0) begin
            boundary <= 1'b0;
         end else begin
            cnt1 <= cnt1 - 17'h00001;
         end
      end
   end

   // ***********************************************
   // Periodic refresh and load tracking
   // ***********************************************
   logic [11:0] ref_cnt;
   logic        blank;
   logic        forced_pend;
   logic        demand_seen;
   logic [3:0]  level;
   logic        in_reg;
   assign in_reg = (mode == MODE_REGULATE);

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ref_cnt <= '0;
         blank   <= 1'b1;
      end else begin
         ref_cnt <= (ref_cnt == 12'(REFRESH_CYC - 1)) ? 12'h000 : ref_cnt + 12'h001;
         blank   <= (ref_cnt == 12'(REFRESH_CYC - 1)) || (ref_cnt < 12'(BLANK_CYC - 1));
      end
   end

   // One full cycle is owed after each blank in regulate mode, whatever the demand
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         forced_pend <= 1'b0;
      end else if (in_reg && ref_cnt == 12'(BLANK_CYC - 1)) begin
         forced_pend <= 1'b1;
      end else if (GATE_O || !in_reg) begin
         forced_pend <= 1'b0;
      end
   end

   // Peak level moves one tenth per refresh period toward the demand
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         level       <= LEVEL_MAX;
         demand_seen <= 1'b0;
      end else if (mode == MODE_CHARGE) begin
         level       <= LEVEL_MAX;
         demand_seen <= 1'b0;
      end else if (ref_cnt == 12'(REFRESH_CYC - 1)) begin
         demand_seen <= 1'b0;
         if (demand_seen && level != LEVEL_MAX) begin
            level <= level + 4'h1;
         end else if (!demand_seen && level != LEVEL_MIN) begin
            level <= level - 4'h1;
         end
      end else if (cmp.fb_demand) begin
         demand_seen <= 1'b1;
      end
   end

   // ***********************************************
   // Switch latch
   // ***********************************************
   logic in_window;
   logic reg_set;
   logic chg_set;
   logic nl_set;
   logic gate_set;
   logic gate_clr;

   assign in_window = ref_cnt < window_end(level);
   assign reg_set   = in_reg && !blank &&
                      (forced_pend || (cmp.fb_demand && in_window && (zed_pulse || prot_out)));
   assign chg_set   = (mode == MODE_CHARGE) && (zed_pulse || prot_out);
   assign nl_set    = (mode == MODE_NOLOAD) && cmp.fb_demand && (zed_pulse || prot_out);
   assign gate_set  = startup_shot || (master && (chg_set || reg_set || nl_set));
   assign gate_clr  = cmp.ilim_trip || cmp.iaux_trip || fault || !(master || startup_shot);

   // Clear wins so a late current trip never stretches the on phase
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         GATE_O <= 1'b0;
      end else if (gate_clr) begin
         GATE_O <= 1'b0;
      end else if (gate_set && !GATE_O) begin
         GATE_O <= 1'b1;
      end
   end

   // ***********************************************
   // Indicator and analog control outputs
   // ***********************************************
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         DONE_O           <= 1'b0;
         DONE_OE_O        <= 1'b0;
         FAULT_O          <= 1'b0;
         FAULT_OE_O       <= 1'b0;
         DETECT_THR_SEL_O <= 1'b0;
         ILIM_LEVEL_O     <= LEVEL_MAX;
      end else begin
         DONE_O           <= 1'b0;
         DONE_OE_O        <= done | fault;
         FAULT_O          <= 1'b0;
         FAULT_OE_O       <= fault;
         DETECT_THR_SEL_O <= boundary;
         ILIM_LEVEL_O     <= level;
      end
   end

   // ***********************************************
   // AHB-Lite slave, zero wait states, always OKAY
   // ***********************************************
   logic [31:0] status;
   always_comb begin
      status = '0;
      status[ST_MODE_LSB +: 2]  = mode;
      status[ST_STATE_LSB +: 2] = state;
      status[ST_MASTER_BIT]     = master;
      status[ST_GATE_BIT]       = GATE_O;
      status[ST_DONE_BIT]       = done;
      status[ST_FAULT_BIT]      = fault;
      status[ST_BOUND_BIT]      = boundary;
      status[ST_LEVEL_LSB +: 4] = level;
      status[ST_REQ_LSB +: 4]   = req_cnt;
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end else begin
         wr_pend <= addr_valid & HWRITE_I;
         wr_addr <= HADDR_I;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl <= CTRL_RESET;
      end else if (wr_pend && hit(wr_addr, CTRL_OFS)) begin
         ctrl <= {31'h0000_0000, HWDATA_I[CTRL_EN_BIT]};
      end
   end

   // Read data is captured in the address phase so it stands all of the data phase
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         HRDATA_O    <= '0;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end else begin
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
         if (addr_valid && !HWRITE_I) begin
            if (hit(HADDR_I, CTRL_OFS)) begin
               HRDATA_O <= ctrl;
            end else if (hit(HADDR_I, STATUS_OFS)) begin
               HRDATA_O <= status;
            end else begin
               HRDATA_O <= '0;
            end
         end
      end
   end

endmodule

// file: test/fcs_sequencer_properties.sv
// Port assertions for the flyback charge sequencer.
// Assumes it is bound to fcs_sequencer; one clock domain.
`timescale 1ns/1ps
module fcs_sequencer_properties #(
   parameter int TIMEOUT_CYCLES = fcs_pkg::TIMEOUT_CYC
) (
   input wire logic              MCLK_I,
   input wire logic              RST_B_I,
   input wire fcs_pkg::fcs_cmp_t CMP_I,
   input wire logic              GATE_O,
   input wire logic              DETECT_THR_SEL_O,
   input wire logic [3:0]        ILIM_LEVEL_O,
   input wire logic              DONE_OE_O,
   input wire logic              FAULT_OE_O,
   input wire logic              HREADYOUT_O,
   input wire logic              HRESP_O
);
   import fcs_pkg::*;
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);
   // Mirror of the refresh counter; both leave reset on the same edge
   logic [11:0] ref_m;
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ref_m <= '0;
      end else begin
         ref_m <= (ref_m == 12'(REFRESH_CYC - 1)) ? 12'h000 : ref_m + 12'h001;
      end
   end
   // ****************************
   // Sequences
   // ****************************
   sequence zed_fall;
      $fell(CMP_I.node_above_thr) && !GATE_O && CMP_I.start && CMP_I.fb_below_low && !DONE_OE_O && !FAULT_OE_O;
   endsequence
   // Feedback pins in the regulation band long enough to pass the synchroniser
   sequence reg_gate_rise;
      !CMP_I.fb_below_low && !CMP_I.fb_above_high && !$past(CMP_I.fb_below_low, 3)
      && !$past(CMP_I.fb_above_high, 3) && $rose(GATE_O);
   endsequence
   sequence start_rise;
      $rose(CMP_I.start) && !GATE_O && !FAULT_OE_O && !CMP_I.supply_lockout;
   endsequence
   // ****************************
   // Properties
   // ****************************
   a_start_delay: assert property (start_rise |-> ##1 (!GATE_O)[*8] ##[180:230] GATE_O)
      else $error("gate start delay wrong");
   a_zed_refire: assert property (zed_fall |-> ##[2:6] GATE_O)
      else $error("no new cycle after detect");
   a_thr_lowers: assert property (zed_fall |-> ##[2:6] DETECT_THR_SEL_O)
      else $error("threshold not lowered");
   a_ilim_ends_on: assert property (CMP_I.ilim_trip && GATE_O |-> ##[1:4] !GATE_O)
      else $error("current limit ignored");
   a_done_target: assert property ($rose(CMP_I.vout_target) && CMP_I.start && CMP_I.fb_below_low && !GATE_O
      |-> ##[2:6] DONE_OE_O)
      else $error("done not raised");
   a_done_holds: assert property ($rose(DONE_OE_O) && CMP_I.vout_target |-> (!GATE_O)[*8])
      else $error("switching after done");
   a_done_fault: assert property (FAULT_OE_O && $past(FAULT_OE_O) |-> DONE_OE_O)
      else $error("fault without done");
   a_lockout_stop: assert property (CMP_I.supply_lockout |-> ##[2:5] (FAULT_OE_O && !GATE_O))
      else $error("lockout ignored");
   a_stop_on_low: assert property ($fell(CMP_I.start) |-> ##5 (!GATE_O)[*3])
      else $error("gate after start low");
   a_charge_level: assert property (CMP_I.fb_below_low[*8] |-> ILIM_LEVEL_O == LEVEL_MAX)
      else $error("charge level not max");
   a_blank_holds: assert property (reg_gate_rise |-> $past(ref_m) >= 12'(BLANK_CYC))
      else $error("gate rose inside refresh blank");
   a_bus_okay: assert property (HRESP_O == 1'b0 && HREADYOUT_O == 1'b1)
      else $error("bus response wrong");
endmodule
bind fcs_sequencer fcs_sequencer_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_fcs_sequencer_properties (
   .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .CMP_I(CMP_I), .GATE_O(GATE_O), .DETECT_THR_SEL_O(DETECT_THR_SEL_O),
   .ILIM_LEVEL_O(ILIM_LEVEL_O), .DONE_OE_O(DONE_OE_O), .FAULT_OE_O(FAULT_OE_O), .HREADYOUT_O(HREADYOUT_O),
   .HRESP_O(HRESP_O));

// file: test/fcs_stage_model.sv
// Power switch, transformer and sense comparators.
// Assumes the gate drive is sampled on the control clock.
`timescale 1ns/1ps
module fcs_stage_model #(
   parameter int ON_CYC = 10
) (
   // Clock and gate
   input  wire logic clk_i,
   input  wire logic gate_i,
   // Scenario knobs
   input  wire logic aux_i,
   input  wire logic node_en_i,
   // Comparators
   output logic      ilim_o = 1'b0,
   output logic      iaux_o = 1'b0,
   output logic      node_o = 1'b0
);
   int on_n  = 0;
   int off_n = 100;
   // Node rings above threshold only after the switch opens
   always @(posedge clk_i) begin
      on_n   <= gate_i ? on_n + 1 : 0;
      off_n  <= gate_i ? 0 : off_n + 1;
      ilim_o <= gate_i && !aux_i && on_n >= ON_CYC;
      iaux_o <= gate_i && aux_i && on_n >= ON_CYC;
      node_o <= node_en_i && !gate_i && off_n < 20;
   end
endmodule

// file: test/flyback_charge_sequencer_bench.sv
// Self-checking bench for the flyback charge sequencer.
// Assumes the stage model and the bound port checker.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module flyback_charge_sequencer_bench;
   import fcs_pkg::*;
   localparam int TMO = 200;
   logic        clk, rst_b, st, fbl, fbh, dem, tgt, lock, aux, node_en, ilim, iaux, node;
   logic        gate, thr, done, done_oe, fault, fault_oe, hsel, hwrite, hready, hresp;
   logic [3:0]  lvl;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   fcs_cmp_t    cmp;
   int          n_fail, cmp_count, cyc, n, g;
   assign cmp = '{st, fbl, fbh, dem, ilim, iaux, tgt, node, lock};
   fcs_sequencer #(.TIMEOUT_CYCLES(TMO)) u_fcs_sequencer (.MCLK_I(clk), .RST_B_I(rst_b), .CMP_I(cmp),
      .GATE_O(gate), .DETECT_THR_SEL_O(thr), .ILIM_LEVEL_O(lvl), .DONE_O(done), .DONE_OE_O(done_oe),
      .FAULT_O(fault), .FAULT_OE_O(fault_oe), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp));
   fcs_stage_model u_fcs_stage_model (.clk_i(clk), .gate_i(gate), .aux_i(aux), .node_en_i(node_en),
      .ilim_o(ilim), .iaux_o(iaux), .node_o(node));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************************
   // Shared tasks
   // ****************************
   task tally_and_finish;
      if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard sized well above the longest scenario
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task wait_gate(input logic v, output int k);
      k = 0;
      do begin @(posedge clk); k++; end while (gate !== v && k < 9000);
   endtask
   // Gate rising edges over k cycles, and the longest spacing before each, counted from the window start or the previous rise
   task count_rises(input int k, output int r, output int gmax);
      logic gp;
      int   gap;
      r = 0;
      gmax = 0;
      gap = 0;
      gp = gate;
      repeat (k) begin
         @(posedge clk);
         gap++;
         if (gate === 1'b1 && gp === 1'b0) begin
            if (gap > gmax) gmax = gap;
            r++;
            gap = 0;
         end
         gp = gate;
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   // ****************************
   // Scenarios
   // ****************************
   task t_regs;
      ahb(1'b0, 32'h0, 32'h0); `CHK(rd, CTRL_RESET)
      ahb(1'b1, 32'h0, 32'h0); ahb(1'b0, 32'h0, 32'h0); `CHK(rd, 32'h0)
      ahb(1'b1, 32'h0, 32'hFFFF_FFFF); ahb(1'b0, 32'h0, 32'h0); `CHK(rd, 32'h1)
      ahb(1'b1, 32'h10, 32'h5); ahb(1'b0, 32'h10, 32'h0); `CHK(rd, 32'h0)
   endtask
   task t_startup;
      st <= 1'b1;
      wait_gate(1'b1, n); `CHK(n >= START_DELAY_CYC && n <= START_DELAY_CYC + 8, 1'b1)
      wait_gate(1'b0, n); `CHK(n <= 14, 1'b1)
      wait_gate(1'b1, n); `CHK(n <= SLOW_DIV_CYC + 8, 1'b1)
      aux <= 1'b1;
      wait_gate(1'b0, n); `CHK(n <= 14, 1'b1)
      ahb(1'b0, 32'h4, 32'h0); `CHK(rd[19:16], 4'h2)
      wait_gate(1'b1, n); `CHK(n >= SLOW_DIV_CYC - 40, 1'b1)
      aux <= 1'b0;
   endtask
   task t_boundary;
      node_en <= 1'b1;
      wait_gate(1'b0, n); wait_gate(1'b1, n); `CHK(n <= 30, 1'b1)
      tick(2); `CHK(thr, 1'b1)
      wait_gate(1'b0, n); wait_gate(1'b1, n); `CHK(n <= 30, 1'b1)
      node_en <= 1'b0;
      wait_gate(1'b0, n); tick(TMO + 60); `CHK(thr, 1'b0)
   endtask
   task t_done;
      st <= 1'b0; tick(10); st <= 1'b1;
      wait_gate(1'b1, n); wait_gate(1'b0, n);
      tgt <= 1'b1; tick(8); `CHK({done_oe, done, gate}, 3'b100)
      ahb(1'b0, 32'h4, 32'h0); `CHK(rd[4], 1'b0)
      tgt <= 1'b0; st <= 1'b0; tick(10); `CHK(gate, 1'b0)
   endtask
   task t_fault;
      st <= 1'b1; wait_gate(1'b1, n);
      lock <= 1'b1; tick(8); `CHK({fault_oe, done_oe, gate, fault}, 4'b1100)
      lock <= 1'b0; tick(8); `CHK(fault_oe, 1'b1)
      st <= 1'b0; tick(8); st <= 1'b1; tick(8); `CHK(fault_oe, 1'b0)
   endtask
   task t_regulate;
      wait_gate(1'b1, n);
      fbl <= 1'b0; tick(8); ahb(1'b0, 32'h4, 32'h0); `CHK(rd[1:0], MODE_REGULATE)
      tick(10 * REFRESH_CYC); `CHK(lvl, LEVEL_MIN)
      count_rises(3 * REFRESH_CYC, n, g); `CHK(n, 3)
      `CHK(g, REFRESH_CYC)
      dem <= 1'b1; node_en <= 1'b1; tick(2 * REFRESH_CYC);
      count_rises(REFRESH_CYC, n, g); `CHK(n > 2, 1'b1)
      dem <= 1'b0; node_en <= 1'b0; tick(8);
      fbh <= 1'b1; tick(8); ahb(1'b0, 32'h4, 32'h0); `CHK(rd[1:0], MODE_NOLOAD)
      fbh <= 1'b0; fbl <= 1'b1; tick(8); ahb(1'b0, 32'h4, 32'h0); `CHK(rd[1:0], MODE_CHARGE)
      tick(4); `CHK(lvl, LEVEL_MAX)
   endtask
   initial begin
      rst_b = 1'b0; st = 1'b0; fbl = 1'b1; fbh = 1'b0; dem = 1'b0; tgt = 1'b0; lock = 1'b0;
      aux = 1'b0; node_en = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hwdata = 32'h0; n_fail = 0; cmp_count = 0; cyc = 0;
      tick(2);
      rst_b <= 1'b1;
      t_regs;
      t_startup;
      t_boundary;
      t_done;
      t_fault;
      t_regulate;
      tally_and_finish();
   end
endmodule
